// [src/cit_core_timing.sv]
// pipeline timing, debug control and data space of the core
`timescale 1ns/1ps
`include "cit_regs.svh"
// Summary of operation
// - opcodes decode with the established compatible encodings and flags.
// - every instruction is counted in single system clocks.
// - most instructions take one clock per program byte.
// - untaken conditional branches finish one clock sooner than taken.
// - no instruction needs more than eight clocks.
// - the instruction set holds 109 distinct instructions.
// - cycle classes follow the published population, divide alone at eight.
// - runs up to 200 MHz (5 ns clock), one instruction per clock at peak.
// - code move reads flash bytes, external data move writes them.
// - the serial test port programs flash and talks to debug logic.
// - breakpoints, watchpoints, run, halt, step and memory access.
// - debug uses no user ram, stack or timers.
// - 256 bytes of data ram and a 128-byte special register space.
module cit_core_timing (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // instruction issue
    input  wire logic                 op_valid,
    input  cit_pkg::cit_op_t          op,
    output logic                      op_ready,
    // retirement
    output logic                      instr_done,
    output logic [1:0]                instr_len,
    output logic [3:0]                instr_cycles,
    // execute-unit data access
    input  wire logic                 dacc_valid,
    input  wire logic                 dacc_wr,
    input  wire logic                 dacc_indir,
    input  wire logic [7:0]           dacc_addr,
    input  wire logic [7:0]           dacc_wdata,
    output logic [7:0]                dacc_rdata,
    output logic                      sfr_hit,
    // flash byte access
    input  wire logic                 flash_wr_en,
    output logic                      code_rd_stb,
    output logic                      flash_wr_stb,
    // debug port
    input  cit_pkg::cit_dbg_t         dbg,
    input  cit_pkg::cit_dmem_t        dbg_mem,
    output logic                      halted,
    output logic [7:0]                dbg_rdata
);
    ////////////////////////////////////////////////////////////////////////
    cit_pkg::cit_tinfo_t info;
    cit_pkg::cit_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt, total;
    logic       accept, bk_hit, watch_hit;
    logic       done_r, done_nxt, crd_r, crd_nxt, fwr_r, fwr_nxt;
    logic [1:0] len_r, len_nxt;
    logic [3:0] cyc_r, cyc_nxt;

    cit_op_decode u_dec (
        .code (op.code),
        .info (info)
    );

    // taken conditional branches pay one extra clock
    assign total = info.cyc + {3'b000, info.cond & op.taken};
    assign bk_hit = dbg.bkpt_en && (op.pc == dbg.bkpt_pc);
    assign watch_hit = dbg.watch_en && dacc_valid
                       && (dacc_addr == dbg.watch_addr);
    // resume and step skip the breakpoint so a halted pc can move on
    assign op_ready = (cnt_r == `CIT_CNT_RST) && !dbg.halt
                      && ((st_r == cit_pkg::CIT_RUN && !bk_hit)
                          || st_r == cit_pkg::CIT_STEP
                          || st_r == cit_pkg::CIT_RESUME);
    assign accept = op_valid && op_ready;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            cit_pkg::CIT_RUN: begin
                if (dbg.halt || watch_hit
                    || (op_valid && cnt_r == `CIT_CNT_RST && bk_hit))
                    st_nxt = cit_pkg::CIT_HALT;
            end
            cit_pkg::CIT_HALT: begin
                if (dbg.step)
                    st_nxt = cit_pkg::CIT_STEP;
                else if (dbg.run)
                    st_nxt = cit_pkg::CIT_RESUME;
            end
            cit_pkg::CIT_STEP: begin
                // an interrupt vector arrives as an ordinary issue
                if (accept || dbg.halt)
                    st_nxt = cit_pkg::CIT_HALT;
            end
            cit_pkg::CIT_RESUME: begin
                if (dbg.halt)
                    st_nxt = cit_pkg::CIT_HALT;
                else if (accept)
                    st_nxt = cit_pkg::CIT_RUN;
            end
            default: st_nxt = cit_pkg::CIT_HALT;
        endcase
    end

    // cycle counter: one count per system clock
    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        len_nxt  = len_r;
        cyc_nxt  = cyc_r;
        if (accept) begin
            cnt_nxt  = total - 4'h1;
            done_nxt = (total == 4'h1);
            len_nxt  = info.len;
            cyc_nxt  = total;
        end else if (cnt_r != `CIT_CNT_RST) begin
            cnt_nxt  = cnt_r - 4'h1;
            done_nxt = (cnt_r == 4'h1);
        end
        crd_nxt = accept && info.code_memory_move;
        fwr_nxt = accept && info.xwr && flash_wr_en;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r  <= cit_pkg::CIT_RUN;
            cnt_r <= `CIT_CNT_RST;
            done_r <= 1'b0;
            len_r <= 2'h0;
            cyc_r <= 4'h0;
            crd_r <= 1'b0;
            fwr_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            len_r <= len_nxt;
            cyc_r <= cyc_nxt;
            crd_r <= crd_nxt;
            fwr_r <= fwr_nxt;
        end
    end

    assign instr_done   = done_r;
    assign instr_len    = len_r;
    assign instr_cycles = cyc_r;
    assign code_rd_stb  = crd_r;
    assign flash_wr_stb = fwr_r;
    assign halted       = (st_r == cit_pkg::CIT_HALT);

    ////////////////////////////////////////////////////////////////////////
    // data ram; debug reaches it on its own port only while halted,
    // so no user byte or stack slot is borrowed
    logic [7:0] ram_r   [`CIT_RAM_DEPTH];
    logic [7:0] ram_nxt [`CIT_RAM_DEPTH];
    logic       we, ram_sel, sfr_nxt, sfr_r;
    logic [7:0] wa, wd, rd_nxt, rd_r, drd_nxt, drd_r;

    // direct addresses from 0x80 up select the special register space
    assign ram_sel = dacc_indir || (dacc_addr < `CIT_SFR_BASE);

    always_comb begin
        we      = 1'b0;
        wa      = dacc_addr;
        wd      = dacc_wdata;
        rd_nxt  = rd_r;
        drd_nxt = drd_r;
        sfr_nxt = 1'b0;
        if (halted) begin
            if (dbg_mem.valid) begin
                we      = dbg_mem.wr;
                wa      = dbg_mem.addr;
                wd      = dbg_mem.wdata;
                drd_nxt = ram_r[dbg_mem.addr];
            end
        end else if (dacc_valid) begin
            we      = dacc_wr && ram_sel;
            sfr_nxt = !ram_sel;
            if (ram_sel)
                rd_nxt = ram_r[dacc_addr];
        end
    end

    generate
        for (genvar i = 0; i < `CIT_RAM_DEPTH; i++) begin : g_ram
            always_comb begin
                ram_nxt[i] = (we && wa == 8'(i)) ? wd : ram_r[i];
            end
            always_ff @(posedge clock) begin
                ram_r[i] <= ram_nxt[i];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_r  <= 8'h00;
            drd_r <= 8'h00;
            sfr_r <= 1'b0;
        end else begin
            rd_r  <= rd_nxt;
            drd_r <= drd_nxt;
            sfr_r <= sfr_nxt;
        end
    end

    assign dacc_rdata = rd_r;
    assign dbg_rdata  = drd_r;
    assign sfr_hit    = sfr_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_div_issue;
        accept && op.code == 8'h84;
    endsequence
    sequence s_div_run;
        (cnt_r == 4'h7) ##7 instr_done;
    endsequence

    a_div_eight: assert property (s_div_issue |=> s_div_run)
        else $error("divide did not retire after eight clocks");
    a_cycle_bound: assert property (
        accept |-> total <= `CIT_MAX_CYC)
        else $error("instruction longer than eight clocks");
    a_one_per_clock: assert property (
        accept && total == 4'h1 |=> instr_done)
        else $error("single clock instruction not retired next cycle");
    a_imm_len: assert property (
        accept && op.code == 8'h74
        |=> !instr_done ##1 (instr_done && instr_cycles == 4'h2))
        else $error("two byte move not two clocks");
    // untaken two-byte branch retires at the second edge after issue
    a_branch_short: assert property (
        accept && op.code == 8'h60 && !op.taken
        |=> (cnt_r == 4'h1 && !instr_done) ##1 instr_done)
        else $error("untaken branch not one clock shorter");
    a_step_once: assert property (
        st_r == cit_pkg::CIT_STEP && accept |=> halted && !op_ready)
        else $error("step ran more than one instruction");
    a_flash_write: assert property (
        accept && info.xwr && flash_wr_en
        |=> flash_wr_stb ##1 !flash_wr_stb)
        else $error("flash write strobe missing or stuck");
    a_code_memory_move_read: assert property (accept && info.code_memory_move |=> code_rd_stb)
        else $error("code move did not read flash");
    a_sfr_space: assert property (
        dacc_valid && !halted && !dacc_indir && dacc_addr[7] |=> sfr_hit)
        else $error("upper direct address did not hit register space");
    a_dbg_ram: assert property (
        halted && dbg_mem.valid && dbg_mem.wr
        ##1 halted && dbg_mem.valid && !dbg_mem.wr
            && dbg_mem.addr == $past(dbg_mem.addr)
        |=> dbg_rdata == $past(dbg_mem.wdata, 2))
        else $error("debug write not read back");
endmodule : cit_core_timing

// [src/cit_regs.svh]
// constants for the instruction timing controller
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

`define CIT_CLK_PERIOD_NS 5
`define CIT_MAX_CYC       4'h8
`define CIT_RAM_DEPTH     256
`define CIT_SFR_BASE      8'h80
`define CIT_CNT_RST       4'h0

`endif

// [src/cit_pkg.sv]
// types shared by the instruction timing controller
package cit_pkg;

    // timing class of one opcode
    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cyc;
        logic       cond;
        logic       code_memory_move;
        logic       xwr;
    } cit_tinfo_t;

    // instruction offered by the fetch stage
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] pc;
        logic        taken;
    } cit_op_t;

    // debug control from the test-access logic
    typedef struct packed {
        logic        halt;
        logic        run;
        logic        step;
        logic        bkpt_en;
        logic [15:0] bkpt_pc;
        logic        watch_en;
        logic [7:0]  watch_addr;
    } cit_dbg_t;

    // debug memory access
    typedef struct packed {
        logic       valid;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cit_dmem_t;

    typedef enum logic [1:0] {
        CIT_RUN    = 2'b00,
        CIT_HALT   = 2'b01,
        CIT_STEP   = 2'b10,
        CIT_RESUME = 2'b11
    } cit_state_t;

endpackage : cit_pkg

// [src/cit_op_decode.sv]
// opcode to length and cycle class decoder
`timescale 1ns/1ps
module cit_op_decode (
    // opcode in
    input  wire logic [7:0]        code,
    // timing class out
    output cit_pkg::cit_tinfo_t    info
);
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = code[7:4];
    assign lo = code[3:0];

    always_comb begin
        info      = '0;
        info.len  = 2'h1;
        case (lo)
            4'h0: begin
                case (hi)
                    4'h0, 4'hE, 4'hF: info.len = 2'h1;
                    4'h1, 4'h2, 4'h3, 4'h9: info.len = 2'h3;
                    default: info.len = 2'h2;
                endcase
                info.cond = (hi >= 4'h1) && (hi <= 4'h7);
                info.code_memory_move = 1'b0;
                info.xwr  = (hi == 4'hF);
            end
            4'h1: info.len = 2'h2;
            4'h2: begin
                case (hi)
                    4'h0, 4'h1: info.len = 2'h3;
                    4'h2, 4'h3, 4'hE, 4'hF: info.len = 2'h1;
                    default: info.len = 2'h2;
                endcase
                info.xwr = (hi == 4'hF);
            end
            4'h3: begin
                info.len  = (hi >= 4'h4 && hi <= 4'h6) ? 2'h3 : 2'h1;
                info.code_memory_move = (hi == 4'h8) || (hi == 4'h9);
                info.xwr  = (hi == 4'hF);
            end
            4'h4: begin
                case (hi)
                    4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF:
                        info.len = 2'h1;
                    4'hB: info.len = 2'h3;
                    default: info.len = 2'h2;
                endcase
                info.cond = (hi == 4'hB);
            end
            4'h5: begin
                case (hi)
                    4'h7, 4'h8, 4'hB, 4'hD: info.len = 2'h3;
                    4'hA: info.len = 2'h1;
                    default: info.len = 2'h2;
                endcase
                info.cond = (hi == 4'hB) || (hi == 4'hD);
            end
            4'h6, 4'h7: begin
                case (hi)
                    4'h7, 4'h8, 4'hA: info.len = 2'h2;
                    4'hB: info.len = 2'h3;
                    default: info.len = 2'h1;
                endcase
                info.cond = (hi == 4'hB);
            end
            default: begin
                case (hi)
                    4'h7, 4'h8, 4'hA, 4'hD: info.len = 2'h2;
                    4'hB: info.len = 2'h3;
                    default: info.len = 2'h1;
                endcase
                info.cond = (hi == 4'hB) || (hi == 4'hD);
            end
        endcase
        // most opcodes take one clock per program byte
        info.cyc = {2'b00, info.len};
        // indirect ram ops need a second clock for the pointer read
        if ((lo == 4'h6 || lo == 4'h7) && info.len == 2'h1)
            info.cyc = 4'h2;
        // code and external data moves reach slower memories
        if ((lo == 4'h0 || lo == 4'h2 || lo == 4'h3) && hi >= 4'hE)
            info.cyc = 4'h3;
        if (info.code_memory_move)
            info.cyc = 4'h3;
        case (code)
            8'hA4: info.cyc = 4'h4;
            8'h84: info.cyc = `CIT_MAX_CYC;
            8'h02, 8'h12: info.cyc = 4'h4;
            8'h22, 8'h32: info.cyc = 4'h5;
            8'h73, 8'h80: info.cyc = 4'h3;
            default: info.cyc = info.cyc;
        endcase
        if (lo == 4'h1)
            info.cyc = 4'h3;
        // cjne @ri resolves the pointer before comparing
        if (info.cond && (lo == 4'h6 || lo == 4'h7))
            info.cyc = 4'h4;
    end
endmodule : cit_op_decode

// [test/cit_fetch_model.sv]
// fetch-stage model that offers opcodes to the timing controller
`timescale 1ns/1ps
module cit_fetch_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // request from the bench
    input  wire logic        rq,
    input  cit_pkg::cit_op_t rq_op,
    // issue handshake
    input  wire logic        op_ready,
    output logic             op_valid,
    output cit_pkg::cit_op_t op,
    output logic             op_acc
);
    logic             valid_r;
    logic             valid_nxt;
    cit_pkg::cit_op_t op_r;
    cit_pkg::cit_op_t op_nxt;

    assign op_acc   = valid_r & op_ready;
    assign op_valid = valid_r;
    assign op       = op_r;

    always_comb begin
        valid_nxt = valid_r;
        op_nxt    = op_r;
        if (rq) begin
            valid_nxt = 1'h1;
            op_nxt    = rq_op;
        end else if (op_acc) begin
            // released fields flip so a stale opcode never looks live
            valid_nxt = 1'h0;
            op_nxt    = ~op_r;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            valid_r <= 1'h0;
            op_r    <= '0;
        end else begin
            valid_r <= valid_nxt;
            op_r    <= op_nxt;
        end
    end
endmodule : cit_fetch_model

// [test/testbench.sv]
// self-checking bench for the instruction timing controller
`timescale 1ns/1ps
module testbench;
    logic clock, sys_rst, rq, op_valid, op_ready, op_acc, instr_done;
    logic dacc_valid, dacc_wr, dacc_indir, sfr_hit, flash_wr_en;
    logic code_rd_stb, flash_wr_stb, halted, saw_rd, saw_wr;
    logic [1:0] instr_len;
    logic [3:0] instr_cycles;
    logic [7:0] dacc_addr, dacc_wdata, dacc_rdata, dbg_rdata;
    cit_pkg::cit_op_t   rq_op, op;
    cit_pkg::cit_dbg_t  dbg;
    cit_pkg::cit_dmem_t dbg_mem;
    int num_errors, checks_done;

    cit_core_timing i_dut (.clock, .sys_rst, .op_valid, .op, .op_ready,
        .instr_done, .instr_len, .instr_cycles, .dacc_valid, .dacc_wr,
        .dacc_indir, .dacc_addr, .dacc_wdata, .dacc_rdata, .sfr_hit,
        .flash_wr_en, .code_rd_stb, .flash_wr_stb, .dbg, .dbg_mem,
        .halted, .dbg_rdata);
    cit_fetch_model i_fetch (.clock, .sys_rst, .rq, .rq_op, .op_ready,
        .op_valid, .op, .op_acc);

    always #2.5 clock = ~clock;

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // n counts edges from the accept edge to the done pulse
    task automatic issue(logic [7:0] c, logic tk, output int n);
        int k;
        @(posedge clock);
        rq    <= 1'h1;
        rq_op <= '{code: c, pc: 16'h0100, taken: tk};
        @(posedge clock);
        rq <= 1'h0;
        k = 0;
        @(negedge clock);
        while (op_acc !== 1'h1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        @(posedge clock);
        saw_rd = 1'h0;
        saw_wr = 1'h0;
        n = 1;
        forever begin
            @(negedge clock);
            saw_rd = saw_rd | code_rd_stb;
            saw_wr = saw_wr | flash_wr_stb;
            if (instr_done === 1'h1 || n > 12) break;
            @(posedge clock);
            n++;
        end
    endtask : issue

    task automatic dacc(logic w, logic ind, logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        dacc_valid <= 1'h1;
        dacc_wr    <= w;
        dacc_indir <= ind;
        dacc_addr  <= a;
        dacc_wdata <= d;
        @(posedge clock);
        dacc_valid <= 1'h0;
        @(negedge clock);
    endtask : dacc

    task automatic dmem(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        dbg_mem <= '{valid: 1'h1, wr: w, addr: a, wdata: d};
        @(posedge clock);
        dbg_mem.valid <= 1'h0;
        @(negedge clock);
    endtask : dmem

    // one edge of halt, run or step request
    task automatic dpulse(logic [2:0] hrs);
        @(posedge clock);
        {dbg.halt, dbg.run, dbg.step} <= hrs;
        @(posedge clock);
        {dbg.halt, dbg.run, dbg.step} <= 3'h0;
        @(negedge clock);
    endtask : dpulse

    task automatic t_timing;
        logic [19:0] tb [20] = '{20'h00011, 20'h74022, 20'h75033,
            20'h26012, 20'hA4014, 20'h84018, 20'h02034, 20'h22015,
            20'h93013, 20'h01023, 20'h40022, 20'h40123, 20'h20033,
            20'h20134, 20'hB6034, 20'hB6135, 20'hD8123, 20'h74122,
            20'h60022, 20'h60123};
        int n;
        foreach (tb[i]) begin
            issue(tb[i][19:12], tb[i][8], n);
            check("clocks", 16'(n), {12'h000, tb[i][3:0]});
            check("over_max", 16'(n > 8), 16'h0000);
            check("instr_cycles", instr_cycles, tb[i][3:0]);
            check("instr_len", instr_len, tb[i][5:4]);
        end
    endtask : t_timing

    task automatic t_burst;
        int d;
        d = 0;
        @(posedge clock);
        rq    <= 1'h1;
        rq_op <= '{code: 8'h00, pc: 16'h0100, taken: 1'h0};
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            if (i == 3) rq <= 1'h0;
            @(negedge clock);
            d += int'(instr_done === 1'h1);
        end
        check("burst_done", 16'(d), 16'h0004);
    endtask : t_burst

    task automatic t_flash;
        int n;
        issue(8'h93, 1'h0, n);
        check("code_rd", saw_rd, 1'h1);
        issue(8'hF0, 1'h0, n);
        check("wr_off", saw_wr, 1'h0);
        flash_wr_en <= 1'h1;
        issue(8'hF0, 1'h0, n);
        check("flash_wr", saw_wr, 1'h1);
        issue(8'hE0, 1'h0, n);
        check("xread", saw_wr, 1'h0);
        flash_wr_en <= 1'h0;
    endtask : t_flash

    task automatic t_data;
        dacc(1'h1, 1'h0, 8'h10, 8'hA5);
        dacc(1'h0, 1'h0, 8'h10, 8'h00);
        check("ram_rd", dacc_rdata, 8'hA5);
        dacc(1'h1, 1'h1, 8'h90, 8'h77);
        check("sfr_ind", sfr_hit, 1'h0);
        dacc(1'h1, 1'h0, 8'h90, 8'h33);
        check("sfr_hit", sfr_hit, 1'h1);
        dacc(1'h0, 1'h1, 8'h90, 8'h00);
        check("upper_ram", dacc_rdata, 8'h77);
    endtask : t_data

    task automatic t_debug;
        int n;
        dpulse(3'h4);
        check("halted", halted, 1'h1);
        check("ready_halt", op_ready, 1'h0);
        dmem(1'h1, 8'h20, 8'h5A);
        dacc(1'h1, 1'h0, 8'h20, 8'h11);
        dmem(1'h0, 8'h20, 8'h00);
        check("dbg_rdata", dbg_rdata, 8'h5A);
        // write then read the same byte on consecutive edges
        @(posedge clock);
        dbg_mem <= '{valid: 1'h1, wr: 1'h1, addr: 8'h21, wdata: 8'hC3};
        @(posedge clock);
        dbg_mem.wr <= 1'h0;
        @(posedge clock);
        dbg_mem.valid <= 1'h0;
        @(negedge clock);
        check("dbg_b2b", dbg_rdata, 8'hC3);
        dpulse(3'h1);
        issue(8'h00, 1'h0, n);
        check("step_clocks", 16'(n), 16'h0001);
        check("step_halt", halted, 1'h1);
        dpulse(3'h2);
        check("resumed", halted, 1'h0);
        dacc(1'h0, 1'h0, 8'h10, 8'h00);
        check("user_ram", dacc_rdata, 8'hA5);
        // one issue takes the core out of resume back to run
        issue(8'h00, 1'h0, n);
        check("resume_run", 16'(n), 16'h0001);
        check("run_again", halted, 1'h0);
    endtask : t_debug

    task automatic t_break;
        int k;
        @(posedge clock);
        dbg.bkpt_en <= 1'h1;
        dbg.bkpt_pc <= 16'h0200;
        rq          <= 1'h1;
        rq_op       <= '{code: 8'h00, pc: 16'h0200, taken: 1'h0};
        @(posedge clock);
        rq <= 1'h0;
        repeat (3) @(negedge clock);
        check("bkpt_halt", halted, 1'h1);
        check("bkpt_hold", op_valid, 1'h1);
        dpulse(3'h2);
        k = 0;
        while (instr_done !== 1'h1 && k < 10) begin
            @(negedge clock);
            k++;
        end
        check("resume_done", instr_done, 1'h1);
        dbg.bkpt_en    <= 1'h0;
        dbg.watch_en   <= 1'h1;
        dbg.watch_addr <= 8'h30;
        dacc(1'h0, 1'h0, 8'h31, 8'h00);
        check("watch_miss", halted, 1'h0);
        dacc(1'h0, 1'h0, 8'h30, 8'h00);
        check("watch_hit", halted, 1'h1);
        dbg.watch_en <= 1'h0;
        dpulse(3'h2);
    endtask : t_break

    initial begin
        #(5 * 5000);
        num_errors++;
        stop_test;
    end

    initial begin
        clock       = 1'h0;
        sys_rst     = 1'h1;
        rq          = 1'h0;
        rq_op       = '0;
        dacc_valid  = 1'h0;
        dacc_wr     = 1'h0;
        dacc_indir  = 1'h0;
        dacc_addr   = 8'h00;
        dacc_wdata  = 8'h00;
        flash_wr_en = 1'h0;
        dbg         = '0;
        dbg_mem     = '0;
        num_errors  = 0;
        checks_done = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'h0;
        @(negedge clock);
        check("rst_done", instr_done, 1'h0); // RESET
        check("rst_cycles", instr_cycles, 4'h0); // RESET
        check("rst_ready", op_ready, 1'h1); // RESET
        check("rst_halted", halted, 1'h0); // RESET
        t_timing;
        t_burst;
        t_flash;
        t_data;
        t_debug;
        t_break;
        stop_test;
    end
endmodule : testbench
